// ---- include/bmu_pkg.sv ----
// package for the bit manipulation unit: opcodes, states, carriers
package bmu_pkg;

  localparam int DATA_W = 8;
  localparam int IDX_W = 3;
  localparam int ADDR_W = 16;
  localparam int REG_SEL_W = 4;
  localparam logic [7:0] WO_READ_VALUE = 8'hFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // operation codes presented on the command port
  typedef enum logic [3:0] {
    SET_BIT_OP = 4'h0,
    CLEAR_BIT_OP = 4'h1,
    INVERT_BIT_OP = 4'h2,
    TEST_BIT_OP = 4'h3,
    CARRY_AND_OP = 4'h4,
    CARRY_AND_INVERTED_OP = 4'h5,
    CARRY_OR_OP = 4'h6,
    CARRY_OR_INVERTED_OP = 4'h7,
    CARRY_XOR_OP = 4'h8,
    CARRY_XOR_INVERTED_OP = 4'h9,
    LOAD_CARRY_OP = 4'hA,
    LOAD_CARRY_INVERTED_OP = 4'hB,
    STORE_CARRY_OP = 4'hC,
    STORE_CARRY_INVERTED_OP = 4'hD
  } bmu_op_e;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REG = 3'b001,
    ST_MEM_RD = 3'b010,
    ST_MEM_WAIT = 3'b011,
    ST_MEM_WR = 3'b100,
    ST_DONE = 3'b101
  } bmu_state_e;

  // one instruction as issued by the decoder
  typedef struct packed {
    bmu_op_e op;
    logic idxFromReg;
    logic [IDX_W-1:0] immIdx;
    logic [REG_SEL_W-1:0] idxReg;
    logic operandInMem;
    logic [REG_SEL_W-1:0] operandReg;
    logic [ADDR_W-1:0] operandAddr;
  } bmu_cmd_s;

  // flag results returned to the condition code register
  typedef struct packed {
    logic carryValid;
    logic carry;
    logic zeroValid;
    logic zero;
  } bmu_flags_s;

endpackage

// ---- hdl/bmu_bit_manipulation_unit.sv ----
// bit manipulation datapath with register and memory read-modify-write
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`timescale 1ns/1ps

module bmu_bit_manipulation_unit
  import bmu_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clkEn,
  // command port
  input wire logic cmdValid,
  output logic cmdReady,
  input wire bmu_cmd_s cmd,
  input wire logic carryIn,
  // general register file access
  output logic [REG_SEL_W-1:0] idxRegSel,
  input wire logic [DW-1:0] idxRegData,
  output logic [REG_SEL_W-1:0] opRegSel,
  input wire logic [DW-1:0] opRegData,
  output logic regWrEn,
  output logic [REG_SEL_W-1:0] regWrSel,
  output logic [DW-1:0] regWrData,
  // internal byte bus
  output logic memRdEn,
  output logic memWrEn,
  output logic [AW-1:0] memAddr,
  output logic [DW-1:0] memWrData,
  input wire logic memAck,
  input wire logic [DW-1:0] memRdData,
  input wire logic memWriteOnly,
  input wire logic memIsPort,
  input wire logic [DW-1:0] portDirection,
  input wire logic [DW-1:0] portOutputLatch,
  input wire logic [DW-1:0] portPins,
  // results
  output logic doneValid,
  output bmu_flags_s flagsOut
);

  // ------------------------------------------------------------------
  // notes
  // ------------------------------------------------------------------
  // one instruction at a time; ready returns after the finish pulse
  // memory writes hold strobe, address and data until acknowledged
  // write data is valid from the first cycle of the strobe
  // a low clock enable freezes every stage, the synchroniser too
  // write-back of a port byte copies input pin levels into the latch

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------

  // pick one bit; index 0 is the least significant bit
  function automatic logic pickBit(input logic [DW-1:0] b,
                                   input logic [IDX_W-1:0] i);
    pickBit = b[i];
  endfunction

  // true for the operations that write the operand back
  function automatic logic isModify(input bmu_op_e o);
    case (o)
      SET_BIT_OP, CLEAR_BIT_OP, INVERT_BIT_OP,
      STORE_CARRY_OP, STORE_CARRY_INVERTED_OP: isModify = 1'b1;
      default: isModify = 1'b0;
    endcase
  endfunction

  // inverted variants take the immediate index only
  function automatic logic immOnly(input bmu_op_e o);
    case (o)
      CARRY_AND_INVERTED_OP, CARRY_OR_INVERTED_OP,
      CARRY_XOR_INVERTED_OP, LOAD_CARRY_INVERTED_OP,
      STORE_CARRY_INVERTED_OP: immOnly = 1'b1;
      default: immOnly = 1'b0;
    endcase
  endfunction

  // write one bit into a byte, other bits untouched
  function automatic logic [DW-1:0] putBit(input logic [DW-1:0] b,
                                           input logic [IDX_W-1:0] i,
                                           input logic v);
    putBit = b;
    putBit[i] = v;
  endfunction

  // per bit: take the new level where two stages agree, else hold
  function automatic logic [DW-1:0] pinAgree(input logic [DW-1:0] a,
                                             input logic [DW-1:0] b,
                                             input logic [DW-1:0] old);
    pinAgree = (~(a ^ b) & a) | ((a ^ b) & old);
  endfunction

  // index source: register only where the variant allows it
  function automatic logic [IDX_W-1:0] pickIndex(input bmu_cmd_s c,
                                                 input logic [DW-1:0] r);
    if (c.idxFromReg && !immOnly(c.op)) begin
      pickIndex = r[IDX_W-1:0];
    end else begin
      pickIndex = c.immIdx;
    end
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  bmu_state_e state_q;
  bmu_cmd_s cmd_q;
  logic carry_q;
  logic [IDX_W-1:0] idx_q;
  logic [DW-1:0] byte_q;
  logic [DW-1:0] newByte;
  logic newCarry;
  logic newZero;
  logic selBit;
  logic [DW-1:0] readByte;
  logic [DW-1:0] opByte;
  logic [DW-1:0] pinMeta_q;
  logic [DW-1:0] pinSync_q;
  logic [DW-1:0] pinLate_q;
  logic [DW-1:0] pinLevel_q;
  logic finishNow;

  assign cmdReady = (state_q == ST_IDLE);
  assign idxRegSel = cmd.idxReg;
  assign opRegSel = cmd_q.operandReg;

  // byte seen on a memory read, shaped by location kind
  // a write-only location rewrites all its other bits as ones, so
  // software should keep a shadow copy in ordinary memory
  // input pins read back as their synchronised levels
  always_comb begin
    if (memWriteOnly) begin
      readByte = WO_READ_VALUE;
    end else if (memIsPort) begin
      readByte = (portDirection & portOutputLatch) |
                 (~portDirection & pinLevel_q);
    end else begin
      readByte = memRdData;
    end
  end

  // operand byte: live read data while waiting on the bus, else the
  // captured memory byte or the register contents
  assign opByte = (state_q == ST_MEM_WAIT) ? readByte :
                  cmd_q.operandInMem ? byte_q : opRegData;
  assign selBit = pickBit(opByte, idx_q);

  // instruction finishes on this edge
  assign finishNow = (state_q == ST_REG) ||
                     (state_q == ST_MEM_WR && memAck) ||
                     (state_q == ST_MEM_WAIT && memAck &&
                      !isModify(cmd_q.op));

  // bit modification and flag arithmetic
  always_comb begin
    newByte = opByte;
    newCarry = carry_q;
    newZero = 1'b0;
    case (cmd_q.op)
      SET_BIT_OP: newByte = putBit(opByte, idx_q, 1'b1);
      CLEAR_BIT_OP: newByte = putBit(opByte, idx_q, 1'b0);
      INVERT_BIT_OP: newByte = putBit(opByte, idx_q, ~selBit);
      TEST_BIT_OP: newZero = ~selBit;
      CARRY_AND_OP: newCarry = carry_q & selBit;
      CARRY_AND_INVERTED_OP: newCarry = carry_q & ~selBit;
      CARRY_OR_OP: newCarry = carry_q | selBit;
      CARRY_OR_INVERTED_OP: newCarry = carry_q | ~selBit;
      CARRY_XOR_OP: newCarry = carry_q ^ selBit;
      CARRY_XOR_INVERTED_OP: newCarry = carry_q ^ ~selBit;
      LOAD_CARRY_OP: newCarry = selBit;
      LOAD_CARRY_INVERTED_OP: newCarry = ~selBit;
      STORE_CARRY_OP: newByte = putBit(opByte, idx_q, carry_q);
      STORE_CARRY_INVERTED_OP:
        newByte = putBit(opByte, idx_q, ~carry_q);
      default: newByte = opByte;
    endcase
  end

  // ------------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------------
  // three stages; a level counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      pinLate_q <= '0;
      pinLevel_q <= '0;
    end else if (clkEn) begin
      pinMeta_q <= portPins; // only stage two reads this
      pinSync_q <= pinMeta_q;
      pinLate_q <= pinSync_q;
      pinLevel_q <= pinAgree(pinSync_q, pinLate_q, pinLevel_q);
    end
  end

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else if (clkEn) begin
      case (state_q)
        ST_IDLE: begin
          if (cmdValid) begin
            state_q <= cmd.operandInMem ? ST_MEM_RD : ST_REG;
          end
        end
        ST_REG: state_q <= ST_DONE;
        ST_MEM_RD: state_q <= ST_MEM_WAIT;
        ST_MEM_WAIT: begin
          if (memAck) begin
            state_q <= isModify(cmd_q.op) ? ST_MEM_WR : ST_DONE;
          end
        end
        ST_MEM_WR: begin
          if (memAck) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // capture command, carry and bit index on acceptance
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_q <= '0;
      carry_q <= 1'b0;
      idx_q <= '0;
    end else if (clkEn && cmdValid && state_q == ST_IDLE) begin
      cmd_q <= cmd;
      carry_q <= carryIn;
      idx_q <= pickIndex(cmd, idxRegData);
    end
  end

  // memory byte captured during the read phase
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      byte_q <= RESET_BYTE;
    end else if (clkEn && state_q == ST_MEM_WAIT && memAck) begin
      byte_q <= readByte;
    end
  end

  // ------------------------------------------------------------------
  // bus read and write outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      memRdEn <= 1'b0;
      memWrEn <= 1'b0;
      memAddr <= '0;
      memWrData <= RESET_BYTE;
    end else if (clkEn) begin
      memRdEn <= 1'b0;
      memWrEn <= 1'b0;
      if (state_q == ST_MEM_RD) begin
        memRdEn <= 1'b1;
        memAddr <= cmd_q.operandAddr;
      end
      if (state_q == ST_MEM_WAIT && memAck && isModify(cmd_q.op)) begin
        memWrEn <= 1'b1;
        memWrData <= newByte;
      end
      if (state_q == ST_MEM_WR) begin
        memWrEn <= !memAck;
        memWrData <= newByte;
      end
    end
  end

  // ------------------------------------------------------------------
  // register write-back
  // ------------------------------------------------------------------
  // modified byte returned to the general register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      regWrEn <= 1'b0;
      regWrSel <= '0;
      regWrData <= RESET_BYTE;
    end else if (clkEn) begin
      regWrEn <= 1'b0;
      if (state_q == ST_REG) begin
        regWrEn <= isModify(cmd_q.op);
        regWrSel <= cmd_q.operandReg;
        regWrData <= newByte;
      end
    end
  end

  // ------------------------------------------------------------------
  // completion and flag results
  // ------------------------------------------------------------------
  // one-cycle finish pulse
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      doneValid <= 1'b0;
    end else if (clkEn) begin
      doneValid <= finishNow;
    end
  end

  // flags held from one finish to the next
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flagsOut <= '0;
    end else if (clkEn && finishNow) begin
      flagsOut.carryValid <= !isModify(cmd_q.op) &&
                             cmd_q.op != TEST_BIT_OP;
      flagsOut.carry <= newCarry;
      flagsOut.zeroValid <= cmd_q.op == TEST_BIT_OP;
      flagsOut.zero <= newZero;
    end
  end

endmodule

// ---- tb/bmu_mem_model.sv ----
// behavioural byte bus partner with prompt or slow acknowledge
`timescale 1ns/1ps
module bmu_mem_model (
  // bus from the unit and bench controls
  input wire logic clk_sys, memRdEn, memWrEn, slow,
  input wire logic [7:0] rdByte,
  // answers
  output logic memAck,
  output logic [7:0] memRdData
);
  logic [1:0] cntQ = 2'h0;
  logic pendQ = 1'b0;
  initial memAck = 1'b0;
  initial memRdData = 8'hA5;
  // ack after one or three waits; data churns when not acked
  always @(posedge clk_sys) begin
    memAck <= 1'b0;
    memRdData <= ~memRdData;
    if (memRdEn)
      pendQ <= 1'b1;
    if ((memRdEn || pendQ || memWrEn) && !memAck) begin
      cntQ <= cntQ + 2'h1;
      if (cntQ == (slow ? 2'h3 : 2'h1)) begin
        memAck <= 1'b1;
        cntQ <= 2'h0;
        pendQ <= 1'b0;
        memRdData <= rdByte;
      end
    end
  end
endmodule

// ---- tb/bmu_checker_asserts.sv ----
// port checker for the bit manipulation unit
`timescale 1ns/1ps
module bmu_checker
  import bmu_pkg::*;
#(parameter int DW = 8, parameter int AW = 16) (
  // watched ports
  input wire logic clk_sys, srst, clkEn, cmdValid, cmdReady, regWrEn,
  input wire logic memRdEn, memWrEn, memAck, doneValid,
  input wire bmu_cmd_s cmd,
  input wire bmu_flags_s flagsOut,
  input wire logic [AW-1:0] memAddr,
  input wire logic [DW-1:0] memWrData
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic take, nonMod;
  // accepted command and whether it leaves the operand alone
  assign take = cmdValid && cmdReady && clkEn;
  assign nonMod = cmd.op inside {[TEST_BIT_OP:LOAD_CARRY_INVERTED_OP]};
  a_busy_refuse: assert property (
    take |=> !cmdReady) else $error("command taken while busy");
  a_reg_latency: assert property (
    take && !cmd.operandInMem |-> ##[2:3] doneValid) else $error("late");
  a_read_issue: assert property (
    take && cmd.operandInMem |-> ##[1:3] memRdEn) else $error("no read");
  a_keep_reg: assert property (
    take && nonMod |-> !regWrEn [*4]) else $error("register written");
  a_keep_mem: assert property (
    take && nonMod && cmd.operandInMem |-> !memWrEn [*8])
    else $error("memory written");
  a_write_hold: assert property (
    memWrEn && !memAck |=> memWrEn && $stable(memWrData)
    && $stable(memAddr)) else $error("write not held");
  a_write_done: assert property (
    memWrEn && memAck |=> doneValid && !memWrEn) else $error("no finish");
  a_reg_write: assert property (
    regWrEn |-> doneValid) else $error("register write off done");
  a_done_pulse: assert property (
    doneValid |=> !doneValid) else $error("done too long");
  a_flags_hold: assert property (
    !doneValid |-> $stable(flagsOut)) else $error("flags moved");
endmodule

bind bmu_bit_manipulation_unit bmu_checker #(.DW(DW), .AW(AW)) u_chk (
  .clk_sys, .srst, .clkEn, .cmdValid, .cmdReady, .regWrEn, .memRdEn,
  .memWrEn, .memAck, .doneValid, .cmd, .flagsOut, .memAddr, .memWrData);

// ---- tb/bit_manipulation_unit_test.sv ----
// self-checking bench for the bit manipulation unit
`timescale 1ns/1ps
module bit_manipulation_unit_test;
  import bmu_pkg::*;
  logic clk_sys = '0, srst = '1, cmdValid = '0, carryIn = '0, slow = '0;
  logic memWriteOnly = '0, memIsPort = '0;
  logic [7:0] portDirection = '0, portOutputLatch = '0, portPins = '0;
  logic [7:0] rdByte = '0, regs [16];
  logic cmdReady, regWrEn, memRdEn, memWrEn, memAck, doneValid;
  logic [3:0] idxRegSel, opRegSel, regWrSel;
  logic [7:0] regWrData, memWrData, memRdData;
  logic [15:0] memAddr;
  bmu_flags_s flagsOut;
  bmu_cmd_s cmd = '0;
  logic [31:0] seed = 32'h103CCDAB;
  int n_fail = 0, num_checks = 0, cyc = 0;
  wire logic [7:0] idxRegData = regs[idxRegSel];
  wire logic [7:0] opRegData = regs[opRegSel];

  bmu_bit_manipulation_unit u_dut (.clk_sys, .srst, .clkEn(1'b1),
    .cmdValid, .cmdReady, .cmd, .carryIn, .idxRegSel, .idxRegData,
    .opRegSel, .opRegData, .regWrEn, .regWrSel, .regWrData, .memRdEn,
    .memWrEn, .memAddr, .memWrData, .memAck, .memRdData, .memWriteOnly,
    .memIsPort, .portDirection, .portOutputLatch, .portPins, .doneValid,
    .flagsOut);
  bmu_mem_model u_mem (.clk_sys, .memRdEn, .memWrEn, .slow, .rdByte,
    .memAck, .memRdData);

  initial forever #10 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // reference result, then one command through the unit
  task automatic run_op(input bmu_cmd_s c, input logic cy);
    logic [7:0] b, nb, gotW;
    logic [15:0] gotA, rdA;
    logic [2:0] ix;
    logic sb, ec, mod, wr, cv, tz, inv;
    int n;
    b = memWriteOnly ? WO_READ_VALUE : rdByte;
    if (memIsPort && !memWriteOnly)
      b = portDirection & portOutputLatch | ~portDirection & portPins;
    if (!c.operandInMem)
      b = regs[c.operandReg];
    inv = c.op inside {CARRY_AND_INVERTED_OP, CARRY_OR_INVERTED_OP,
      CARRY_XOR_INVERTED_OP, LOAD_CARRY_INVERTED_OP, STORE_CARRY_INVERTED_OP};
    tz = c.op == TEST_BIT_OP;
    ix = c.idxFromReg && !inv ? regs[c.idxReg][2:0] : c.immIdx;
    sb = b[ix];
    nb = b;
    ec = 1'b0;
    mod = c.op inside {[SET_BIT_OP:INVERT_BIT_OP], [STORE_CARRY_OP:4'hD]};
    cv = c.op inside {[CARRY_AND_OP:LOAD_CARRY_INVERTED_OP]};
    case (c.op)
      SET_BIT_OP: nb[ix] = 1'b1;
      CLEAR_BIT_OP: nb[ix] = 1'b0;
      INVERT_BIT_OP: nb[ix] = !sb;
      CARRY_AND_OP: ec = cy & sb;
      CARRY_AND_INVERTED_OP: ec = cy & !sb;
      CARRY_OR_OP: ec = cy | sb;
      CARRY_OR_INVERTED_OP: ec = cy | !sb;
      CARRY_XOR_OP: ec = cy ^ sb;
      CARRY_XOR_INVERTED_OP: ec = cy ^ !sb;
      LOAD_CARRY_OP: ec = sb;
      LOAD_CARRY_INVERTED_OP: ec = !sb;
      STORE_CARRY_OP: nb[ix] = cy;
      STORE_CARRY_INVERTED_OP: nb[ix] = !cy;
      default: ec = 1'b0;
    endcase
    cmd = c;
    carryIn = cy;
    cmdValid = 1'b1;
    @(posedge clk_sys);
    #1 cmdValid = 1'b0;
    wr = 1'b0;
    rdA = ~c.operandAddr;
    n = 0;
    while (doneValid !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
      if (memRdEn === 1'b1) rdA = memAddr;
      if (regWrEn === 1'b1 || (memWrEn & memAck) === 1'b1) begin
        wr = 1'b1;
        gotW = regWrEn ? regWrData : memWrData;
        gotA = regWrEn ? 16'(regWrSel) : memAddr;
      end
    end
    chk(16'(doneValid), 16'h1);
    chk(16'(wr), 16'(mod));
    if (mod) chk(16'(gotW), 16'(nb));
    if (mod) chk(gotA, c.operandInMem ? c.operandAddr : c.operandReg);
    if (c.operandInMem) chk(rdA, c.operandAddr);
    chk({flagsOut.carryValid, flagsOut.zeroValid}, {cv, tz});
    if (cv) chk(16'(flagsOut.carry), 16'(ec));
    if (tz) chk(16'(flagsOut.zero), 16'(!sb));
  endtask

  // cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    bmu_cmd_s c;
    logic [31:0] r, q;
    foreach (regs[i])
      regs[i] = 8'(i * 37);
    repeat (6) @(posedge clk_sys);
    #1 srst = 1'b0;
    // write-only location read as ones, then bit 0 cleared
    @(posedge clk_sys);
    #1 memWriteOnly = 1'b1;
    c = '0;
    c.op = CLEAR_BIT_OP;
    c.operandInMem = 1'b1;
    run_op(c, 1'b0);
    // port read mixes pins and latch, then bit 0 set
    @(posedge clk_sys);
    #1 {memWriteOnly, memIsPort} = 2'h1;
    {portDirection, portOutputLatch, portPins} = 24'h3F8040;
    c.op = SET_BIT_OP;
    run_op(c, 1'b0);
    $display("directed tests done");
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      q = rnd();
      @(posedge clk_sys);
      #1 c.op = bmu_op_e'(r[3:0] % 4'hE);
      c.idxFromReg = r[4];
      {c.immIdx, c.idxReg, c.operandInMem, c.operandReg} = r[16:5];
      c.operandAddr = q[15:0];
      {memWriteOnly, memIsPort, slow} = {r[17] & r[18], r[19], r[20]};
      {portDirection, portOutputLatch, portPins, rdByte} = q;
      regs[r[24:21]] = r[31:24];
      run_op(c, r[25]);
    end
    $display("random tests done");
    stop_test();
  end
endmodule
